// >>> inc/vfd_pkg.sv
package vfd_pkg;
  localparam int FETCH_BITS = 256;
  localparam int SLOT_BITS = 32;
  localparam int SLOTS = FETCH_BITS / SLOT_BITS;
  localparam int SIDES = 2;
  localparam int UNITS_PER_SIDE = 4;
  localparam int UNITS = SIDES * UNITS_PER_SIDE;
  localparam int REGS_PER_SIDE = 32;
  localparam int REG_IDX_BITS = 5;
  localparam int ALL_REGS = SIDES * REGS_PER_SIDE;
  localparam int FETCH_STEP_BYTES = FETCH_BITS / 8;
  localparam logic [31:0] FETCH_RESET_ADDR = 32'h0000_0000;

  // instruction field positions
  localparam int CHAIN_BIT = 0;
  localparam int SIDE_BIT = 1;
  localparam int UNIT_LSB = 2;
  localparam int OPC_LSB = 4;
  localparam int XPATH_BIT = 9;
  localparam int SRC2_LSB = 10;
  localparam int SRC1_LSB = 15;
  localparam int DST_LSB = 20;
  localparam int MODE_LSB = 25;
  localparam int WIDE_BIT = 27;

  typedef enum logic [1:0] {UNIT_L = 2'h0, UNIT_S = 2'h1, UNIT_M = 2'h2, UNIT_D = 2'h3} vfd_unit_t;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ALU = 5'h01, OP_LOGIC = 5'h02, OP_SHIFT = 5'h03, OP_BRANCH = 5'h04,
    OP_MUL = 5'h08, OP_MULADD = 5'h09, OP_MULSUB = 5'h0a, OP_MUL16X32 = 5'h0b,
    OP_BITCNT = 5'h0c, OP_ROTATE = 5'h0d, OP_GFMUL = 5'h0e, OP_VSHIFT = 5'h0f,
    OP_LOAD = 5'h10, OP_STORE = 5'h11
  } vfd_op_t;

  // mode field: packing for arithmetic, access size for memory ops
  typedef enum logic [1:0] {PACK_W32 = 2'h0, PACK_H16X2 = 2'h1, PACK_B8X4 = 2'h2, PACK_RSVD = 2'h3} vfd_pack_t;
  typedef enum logic [1:0] {MEM_BYTE = 2'h0, MEM_HALF = 2'h1, MEM_WORD = 2'h2, MEM_DWORD = 2'h3} vfd_size_t;

  typedef struct packed {
    logic valid;
    logic [SLOT_BITS-1:0] instr;
    vfd_op_t op;
    logic [1:0] mode;
    logic illegal;
    logic wide;
    logic side;
    logic [REG_IDX_BITS-1:0] dstNorm;
    logic [REG_IDX_BITS-1:0] dstLong;
  } vfd_issue_t;

  typedef struct packed {
    logic req;
    logic take;
    logic [31:0] addr;
  } vfd_fetch_req_t;

  typedef struct packed {
    logic valid;
    logic [FETCH_BITS-1:0] data;
  } vfd_fetch_rsp_t;
endpackage

// >>> hw/vfd_fetch_dispatch.sv
// Contract
// - fetch reads 256-bit packets of eight 32-bit instruction slots
// - lsb 1 chains the following instruction into the same execute packet
// - lsb 0 ends the execute packet; next instruction starts a new one
// - an execute packet holds at most eight instructions
// - execute packets may run across a fetch packet boundary
// - one execute packet dispatched per clock cycle
// - next fetch only after all current execute packets are dispatched; code requests it early when only a crossing tail is left
// - multiplies always go to a multiply unit, never elsewhere
// - multiply unit does dual 16x16 or quad 8x8 per cycle
// - multiply unit also does 16x32, dual mul add/sub, quad mul add
// - multiply unit also does bit count, rotate, galois multiply, variable shift
// - logic and shift units do arithmetic, logic and branch each cycle
// - arithmetic and logic come as 32-bit, dual 16-bit or quad 8-bit
// - loads and stores address byte, half-word, word or doubleword
// - wide multiply result: upper word to long dst, lower to dst
// - two sides, four units each, thirty-two 32-bit registers per side
// - one stall when cross path reads a register written last cycle
`timescale 1ns/1ns
module vfd_fetch_dispatch #(
  parameter int MAX_EP = 8,
  parameter logic [31:0] START_ADDR = vfd_pkg::FETCH_RESET_ADDR
) (
  input wire logic ref_clk,
  input wire logic rst,
  output vfd_pkg::vfd_fetch_req_t fetchOut,
  input wire vfd_pkg::vfd_fetch_rsp_t fetchIn,
  output vfd_pkg::vfd_issue_t [vfd_pkg::UNITS-1:0] issueOut,
  output logic issueValid,
  output logic [3:0] issueCount,
  output logic crossStall,
  output logic unitConflict
);
  import vfd_pkg::*;

  // refused at elaboration, before any logic is built on a bad value
  if (MAX_EP < 1 || MAX_EP > SLOTS) begin : g_bad_ep
    $error("MAX_EP must be 1..8");
  end
  if (START_ADDR[4:0] != 5'h00) begin : g_bad_addr
    $error("START_ADDR must be packet aligned");
  end

  function automatic vfd_issue_t decodeInstr(input logic [SLOT_BITS-1:0] ins);
    vfd_issue_t d;
    d = '0;
    d.valid = 1'b1;
    d.instr = ins;
    d.op = vfd_op_t'(ins[OPC_LSB +: 5]);
    d.mode = ins[MODE_LSB +: 2];
    d.side = ins[SIDE_BIT];
    d.dstNorm = ins[DST_LSB +: REG_IDX_BITS];
    d.dstLong = ins[DST_LSB +: REG_IDX_BITS] + 5'h01;
    case (d.op)
      OP_NOP, OP_BRANCH, OP_BITCNT, OP_ROTATE, OP_GFMUL, OP_VSHIFT: d.illegal = 1'b0;
      OP_ALU, OP_LOGIC, OP_SHIFT: d.illegal = (d.mode == PACK_RSVD);
      OP_MUL, OP_MULSUB: d.illegal = (d.mode != PACK_H16X2) && (d.mode != PACK_B8X4);
      OP_MULADD: d.illegal = (d.mode == PACK_W32) || (d.mode == PACK_RSVD);
      OP_MUL16X32: d.illegal = 1'b0;
      OP_LOAD, OP_STORE: d.illegal = 1'b0; // all four sizes legal
      default: d.illegal = 1'b1;
    endcase
    // split result: upper word to the long destination
    d.wide = ins[WIDE_BIT] && (d.op == OP_MUL16X32 || d.op == OP_MUL || d.op == OP_MULSUB);
    return d;
  endfunction

  function automatic logic isMulOp(input vfd_op_t op);
    return op inside {OP_MUL, OP_MULADD, OP_MULSUB, OP_MUL16X32, OP_BITCNT, OP_ROTATE, OP_GFMUL, OP_VSHIFT};
  endfunction

  function automatic logic [2:0] unitIndex(input logic [SLOT_BITS-1:0] ins);
    logic [1:0] u;
    u = ins[UNIT_LSB +: 2];
    if (isMulOp(vfd_op_t'(ins[OPC_LSB +: 5]))) u = UNIT_M;
    return {ins[SIDE_BIT], u};
  endfunction

  logic [FETCH_BITS-1:0] curPkt_reg;
  logic curValid_reg;
  logic [2:0] pos_reg;
  logic fetchReq_reg;
  logic [31:0] fetchAddr_reg;
  logic [ALL_REGS-1:0] prevWr_reg;
  vfd_issue_t [UNITS-1:0] issueOut_reg;
  logic issueValid_reg;
  logic [3:0] issueCount_reg;
  logic crossStall_reg;
  logic unitConflict_reg;

  logic [SLOT_BITS-1:0] slotW [0:2*SLOTS-1];
  logic [SLOT_BITS-1:0] epInstr [0:SLOTS-1];
  logic [SLOTS-1:0] take;
  logic [3:0] epLen;
  logic needNext;
  logic reach7;
  logic hazard;
  logic canIssue;
  logic fire;
  logic crosses;
  logic [4:0] endPos;
  logic needFetch;
  logic fetchTake;
  vfd_issue_t [UNITS-1:0] unitsNext;
  logic conflictNext;
  logic [ALL_REGS-1:0] wrMask;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign slotW[g] = curPkt_reg[g*SLOT_BITS +: SLOT_BITS];
      assign slotW[g+SLOTS] = fetchIn.data[g*SLOT_BITS +: SLOT_BITS];
    end
  endgenerate

  // walk the chain from the current slot into the incoming packet
  always_comb begin
    logic going;
    logic [4:0] idx;
    going = 1'b1;
    idx = '0;
    take = '0;
    epLen = '0;
    needNext = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      epInstr[i] = '0;
      idx = 5'({2'b00, pos_reg} + 5'(i));
      if (going && i < MAX_EP) begin
        if (idx >= 5'(SLOTS) && !fetchIn.valid) begin
          needNext = 1'b1;
          going = 1'b0;
        end else begin
          take[i] = 1'b1;
          epInstr[i] = slotW[idx[3:0]];
          epLen = 4'(i + 1);
          if (!slotW[idx[3:0]][CHAIN_BIT]) going = 1'b0;
        end
      end
    end
  end

  // tail of the current packet is one open chain past slot 7
  always_comb begin
    logic open;
    open = (pos_reg != 3'h0) || (MAX_EP > SLOTS - 1 ? 1'b0 : 1'b1);
    open = open && (pos_reg != 3'h0);
    for (int i = 0; i < SLOTS; i++) begin
      if (i >= pos_reg && !slotW[i][CHAIN_BIT]) open = 1'b0;
    end
    reach7 = open && (7 - pos_reg < MAX_EP);
  end

  assign endPos = 5'({2'b00, pos_reg} + {1'b0, epLen});
  assign crosses = endPos > 5'(SLOTS);
  assign canIssue = curValid_reg && !needNext;

  // route each chained instruction; first claim on a unit wins
  always_comb begin
    vfd_issue_t d;
    logic [2:0] u;
    d = '0;
    u = '0;
    unitsNext = '0;
    conflictNext = 1'b0;
    hazard = 1'b0;
    wrMask = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (take[i]) begin
        d = decodeInstr(epInstr[i]);
        u = unitIndex(epInstr[i]);
        if (epInstr[i][XPATH_BIT] && prevWr_reg[{~d.side, epInstr[i][SRC2_LSB +: REG_IDX_BITS]}]) begin
          hazard = 1'b1;
        end
        if (unitsNext[u].valid) begin
          conflictNext = 1'b1;
        end else begin
          unitsNext[u] = d;
          if (d.op != OP_NOP && d.op != OP_STORE && d.op != OP_BRANCH) begin
            wrMask[{d.side, d.dstNorm}] = 1'b1;
            if (d.wide) wrMask[{d.side, d.dstLong}] = 1'b1;
          end
        end
      end
    end
  end

  assign fire = canIssue && !hazard;
  // only the crossing tail may be left when the next packet is wanted
  assign needFetch = !curValid_reg || reach7;
  assign fetchTake = fetchIn.valid && fetchReq_reg && (!curValid_reg || (fire && crosses));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      curPkt_reg <= '0;
      curValid_reg <= 1'b0;
      pos_reg <= '0;
    end else if (fetchTake && !curValid_reg) begin
      curPkt_reg <= fetchIn.data;
      curValid_reg <= 1'b1;
      pos_reg <= '0;
    end else if (fire) begin
      if (crosses) begin
        curPkt_reg <= fetchIn.data;
        pos_reg <= endPos[2:0];
      end else if (endPos == 5'(SLOTS)) begin
        curValid_reg <= 1'b0;
        pos_reg <= '0;
      end else begin
        pos_reg <= endPos[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetchReq_reg <= 1'b0;
      fetchAddr_reg <= START_ADDR;
    end else if (fetchTake) begin
      fetchReq_reg <= 1'b0;
      fetchAddr_reg <= fetchAddr_reg + 32'(FETCH_STEP_BYTES);
    end else if (needFetch) begin
      fetchReq_reg <= 1'b1;
    end
  end

  // a stall cycle writes nothing, so the hazard cannot repeat
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevWr_reg <= '0;
      crossStall_reg <= 1'b0;
    end else begin
      prevWr_reg <= fire ? wrMask : '0;
      crossStall_reg <= canIssue && hazard;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      issueOut_reg <= '0;
      issueValid_reg <= 1'b0;
      issueCount_reg <= '0;
      unitConflict_reg <= 1'b0;
    end else begin
      issueOut_reg <= fire ? unitsNext : '0;
      issueValid_reg <= fire;
      issueCount_reg <= fire ? epLen : 4'h0;
      unitConflict_reg <= fire && conflictNext;
    end
  end

  assign fetchOut.req = fetchReq_reg;
  assign fetchOut.take = fetchTake;
  assign fetchOut.addr = fetchAddr_reg;
  assign issueOut = issueOut_reg;
  assign issueValid = issueValid_reg;
  assign issueCount = issueCount_reg;
  assign crossStall = crossStall_reg;
  assign unitConflict = unitConflict_reg;

  logic lastChained;
  logic innerBroken;
  logic mulMisroute;
  always_comb begin
    lastChained = 1'b0;
    innerBroken = 1'b0;
    mulMisroute = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (take[i] && 4'(i + 1) == epLen) lastChained = epInstr[i][CHAIN_BIT];
      if (take[i] && 4'(i + 1) < epLen && !epInstr[i][CHAIN_BIT]) innerBroken = 1'b1;
      if (issueOut_reg[i].valid && isMulOp(issueOut_reg[i].op) && i[1:0] != UNIT_M) mulMisroute = 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ep_size: assert property (issueValid |-> issueCount >= 4'h1 && issueCount <= 4'(MAX_EP))
    else $error("execute packet size out of range");
  a_chain_join: assert property (canIssue |-> !innerBroken)
    else $error("broken chain inside execute packet");
  a_chain_stop: assert property (canIssue && lastChained |-> epLen == 4'(MAX_EP))
    else $error("execute packet ended on a chained slot");
  a_no_early_fetch: assert property ($rose(fetchReq_reg) |-> $past(!curValid_reg || reach7))
    else $error("fetch requested with packets left");
  a_mul_route: assert property (!mulMisroute)
    else $error("multiply on a non-multiply unit");
  a_wide_dst: assert property (issueValid && issueOut[2].wide |-> issueOut[2].dstLong == issueOut[2].dstNorm + 5'h01)
    else $error("long destination mismatch");
  a_cross_stall: assert property (canIssue && hazard |=> crossStall && !issueValid ##1 !crossStall)
    else $error("cross path stall not single cycle");
  a_cross_wait: assert property (curValid_reg && needNext |=> !issueValid)
    else $error("issued before next packet arrived");
  a_cross_issue: assert property (fire && crosses |-> fetchTake ##1 issueValid)
    else $error("crossing packet not issued");
  a_issue_rate: assert property (fire |=> issueValid)
    else $error("ready packet not dispatched next cycle");
  a_conflict_flag: assert property (unitConflict |-> issueValid)
    else $error("unit conflict flagged without an issue");

  c_cross: cover property (fire && crosses);
  c_stall: cover property (crossStall);
  c_full_ep: cover property (issueValid && issueCount == 4'h8);
  c_fetch: cover property (fetchTake ##1 fetchReq_reg);
endmodule

// >>> bench/vfd_prog_mem.sv
`timescale 1ns/1ns
module vfd_prog_mem
  import vfd_pkg::*;
#(
  parameter int DEPTH = 5,
  parameter int SLOW_IDX = 4,
  parameter int SLOW_WAIT = 6
) (
  input wire logic ref_clk,
  input wire vfd_pkg::vfd_fetch_req_t fetchOut,
  output vfd_pkg::vfd_fetch_rsp_t fetchIn
);
  import vfd_pkg::*;
  logic [FETCH_BITS-1:0] prog [DEPTH];
  int waitCnt = 0;
  int idx;
  initial fetchIn = '0;
  assign idx = int'(fetchOut.addr[31:5]);
  // data toggles while not valid so a stale packet can never be mistaken for a fresh one
  always @(posedge ref_clk) begin
    if (fetchIn.valid && fetchOut.take) begin
      fetchIn.valid <= 1'b0;
      fetchIn.data <= ~fetchIn.data;
      waitCnt <= 0;
    end else if (!fetchIn.valid && fetchOut.req && idx < DEPTH && waitCnt >= (idx == SLOW_IDX ? SLOW_WAIT : 0)) begin
      fetchIn.valid <= 1'b1;
      fetchIn.data <= prog[idx];
    end else if (!fetchIn.valid) begin
      fetchIn.data <= ~fetchIn.data;
      waitCnt <= fetchOut.req ? waitCnt + 1 : 0;
    end
  end
endmodule

// >>> bench/vfd_fetch_dispatch_test.sv
`timescale 1ns/1ns
module vfd_fetch_dispatch_test;
  import vfd_pkg::*;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: compare", $time); end end
  typedef struct packed {
    vfd_op_t op;
    logic side;
    vfd_unit_t unit;
    logic [1:0] mode;
    logic wbit;
    logic expWide;
  } vfd_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  vfd_fetch_req_t fetchOut;
  vfd_fetch_rsp_t fetchIn;
  vfd_issue_t [UNITS-1:0] issueOut;
  logic issueValid;
  logic [3:0] issueCount;
  logic crossStall;
  logic unitConflict;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int stallCnt = 0;
  int conflictCnt = 0;
  logic [3:0] gotCnt[$];
  vfd_issue_t [UNITS-1:0] gotIss[$];
  int gotCyc[$];
  int takeCyc[$];
  logic [31:0] takeAddr[$];
  vfd_row_t rows [19];

  vfd_fetch_dispatch dut_u (.ref_clk(ref_clk), .rst(rst), .fetchOut(fetchOut), .fetchIn(fetchIn),
    .issueOut(issueOut), .issueValid(issueValid), .issueCount(issueCount), .crossStall(crossStall),
    .unitConflict(unitConflict));
  vfd_prog_mem mem_u (.ref_clk(ref_clk), .fetchOut(fetchOut), .fetchIn(fetchIn));

  initial forever #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] mk(vfd_op_t op, logic sd, logic [1:0] un, logic [1:0] md, logic wb, logic ch,
    logic [4:0] dst, logic [4:0] s2, logic xp);
    mk = {4'h0, wb, md, dst, 5'h00, s2, xp, op, un, sd, ch};
  endfunction

  function automatic logic [7:0] vmask(vfd_issue_t [UNITS-1:0] iss);
    for (int i = 0; i < UNITS; i++) vmask[i] = iss[i].valid;
  endfunction

  task automatic place(int g, logic [31:0] w);
    mem_u.prog[g / 8][32 * (g % 8) +: 32] = w;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge ref_clk) cyc <= cyc + 1;
  // sampled mid-cycle, where registered outputs and the take strobe are settled
  always @(negedge ref_clk) begin
    if (issueValid === 1'b1) begin
      gotCnt.push_back(issueCount);
      gotIss.push_back(issueOut);
      gotCyc.push_back(cyc);
    end
    if (fetchOut.take === 1'b1) begin
      takeCyc.push_back(cyc);
      takeAddr.push_back(fetchOut.addr);
    end
    if (crossStall === 1'b1) stallCnt++;
    if (unitConflict !== 1'b0) conflictCnt++;
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    int ep;
    int idx;
    rows = '{'{OP_ALU, 1'b0, UNIT_L, 2'h0, 1'b0, 1'b0}, '{OP_ALU, 1'b0, UNIT_S, 2'h1, 1'b0, 1'b0},
      '{OP_ALU, 1'b1, UNIT_L, 2'h2, 1'b0, 1'b0}, '{OP_LOGIC, 1'b1, UNIT_S, 2'h1, 1'b0, 1'b0},
      '{OP_LOGIC, 1'b0, UNIT_L, 2'h2, 1'b0, 1'b0}, '{OP_SHIFT, 1'b0, UNIT_S, 2'h2, 1'b0, 1'b0},
      '{OP_BRANCH, 1'b1, UNIT_S, 2'h0, 1'b0, 1'b0}, '{OP_LOAD, 1'b0, UNIT_D, 2'h0, 1'b0, 1'b0},
      '{OP_LOAD, 1'b1, UNIT_D, 2'h1, 1'b0, 1'b0}, '{OP_STORE, 1'b0, UNIT_D, 2'h2, 1'b0, 1'b0},
      '{OP_STORE, 1'b1, UNIT_D, 2'h3, 1'b0, 1'b0}, '{OP_MUL, 1'b0, UNIT_L, 2'h1, 1'b1, 1'b1},
      '{OP_MULADD, 1'b1, UNIT_S, 2'h2, 1'b0, 1'b0}, '{OP_MULSUB, 1'b0, UNIT_D, 2'h1, 1'b1, 1'b1},
      '{OP_MUL16X32, 1'b1, UNIT_L, 2'h0, 1'b1, 1'b1}, '{OP_BITCNT, 1'b0, UNIT_S, 2'h0, 1'b0, 1'b0},
      '{OP_ROTATE, 1'b1, UNIT_D, 2'h0, 1'b0, 1'b0}, '{OP_GFMUL, 1'b0, UNIT_L, 2'h2, 1'b0, 1'b0},
      '{OP_VSHIFT, 1'b1, UNIT_M, 2'h0, 1'b0, 1'b0}};
    for (int r = 0; r < 19; r++)
      place(r < 16 ? r : r + 10, mk(rows[r].op, rows[r].side, rows[r].unit, rows[r].mode, rows[r].wbit, 1'b0,
        5'(r + 1), 5'h00, 1'b0));
    for (int k = 0; k < 8; k++) place(16 + k, mk(OP_ALU, k / 4, 2'(k), 2'h0, 1'b0, 1'b1, 5'(k + 8), 5'h00, 1'b0));
    place(24, mk(OP_ALU, 1'b0, UNIT_L, 2'h0, 1'b0, 1'b0, 5'h03, 5'h00, 1'b0));
    place(25, mk(OP_ALU, 1'b1, UNIT_L, 2'h0, 1'b0, 1'b0, 5'h09, 5'h03, 1'b1));
    for (int k = 0; k < 3; k++) place(29 + k, mk(OP_ALU, 1'b0, 2'(k), 2'h0, 1'b0, 1'b1, 5'h0a, 5'h00, 1'b0));
    place(32, mk(OP_ALU, 1'b1, UNIT_L, 2'h0, 1'b0, 1'b1, 5'h0b, 5'h00, 1'b0));
    place(33, mk(OP_ALU, 1'b1, UNIT_S, 2'h0, 1'b0, 1'b0, 5'h0c, 5'h00, 1'b0));
    for (int k = 34; k < 40; k++) place(k, mk(OP_ALU, 1'b0, UNIT_L, 2'h0, 1'b0, 1'b0, 5'h0d, 5'h00, 1'b0));
    repeat (2) @(negedge ref_clk);
    `CHK(fetchOut.req, 1'b0)
    `CHK(fetchOut.addr, FETCH_RESET_ADDR)
    `CHK(issueValid, 1'b0)
    rst = 1'b0;
    @(negedge ref_clk);
    `CHK(fetchOut.req, 1'b1)
    for (int w = 0; w < 2000 && gotCnt.size() < 29; w++) @(negedge ref_clk);
    `CHK(gotCnt.size(), 29)
    `CHK(takeAddr.size(), 5)
    for (int k = 0; k < 5 && k < takeAddr.size(); k++) `CHK(takeAddr[k], 32'(k * FETCH_STEP_BYTES))
    if (gotCnt.size() == 29 && takeAddr.size() == 5) begin
      for (int r = 0; r < 19; r++) begin
        ep = r < 16 ? r : r + 3;
        idx = rows[r].op[4:3] == 2'b01 ? {rows[r].side, UNIT_M} : {rows[r].side, rows[r].unit};
        `CHK(gotCnt[ep], 4'h1)
        `CHK(vmask(gotIss[ep]), 8'(1 << idx))
        `CHK(gotIss[ep][idx].op, rows[r].op)
        `CHK(gotIss[ep][idx].mode, rows[r].mode)
        `CHK(gotIss[ep][idx].wide, rows[r].expWide)
        `CHK(gotIss[ep][idx].illegal, 1'b0)
        `CHK(gotIss[ep][idx].dstNorm, 5'(r + 1))
        if (rows[r].expWide) `CHK(gotIss[ep][idx].dstLong, 5'(r + 2))
        if (ep % 8 != 0 && ep < 16) `CHK(gotCyc[ep] - gotCyc[ep - 1], 1)
      end
      `CHK(gotCnt[16], 4'h8)
      `CHK(vmask(gotIss[16]), 8'hff)
      `CHK(takeCyc[1] >= gotCyc[7], 1'b1)
      `CHK(takeCyc[2] >= gotCyc[15], 1'b1)
      `CHK(takeCyc[3] >= gotCyc[16], 1'b1)
      `CHK(stallCnt, 1)
      `CHK(gotCyc[18] - gotCyc[17], 2)
      `CHK(gotCnt[22], 4'h5)
      `CHK(vmask(gotIss[22]), 8'h37)
      `CHK(gotCyc[22] > takeCyc[4], 1'b1)
      `CHK(gotCnt[28], 4'h1)
    end
    `CHK(conflictCnt, 0)
    // second reset in mid-run: everything clears and fetch restarts from the start address
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(fetchOut.req, 1'b0)
    `CHK(fetchOut.addr, FETCH_RESET_ADDR)
    `CHK(issueValid, 1'b0)
    `CHK(crossStall, 1'b0)
    `CHK(unitConflict, 1'b0)
    rst = 1'b0;
    @(negedge ref_clk);
    `CHK(fetchOut.req, 1'b1)
    for (int w = 0; w < 20 && issueValid !== 1'b1; w++) @(negedge ref_clk);
    `CHK(issueCount, 4'h1)
    `CHK(issueOut[0].dstNorm, 5'h01)
    print_verdict();
  end
endmodule
